//--- hdl/sac_pkg.sv
// Constants and types shared by the successive-approximation converter control.
//
// Overview of operation
// - One conversion takes nine and a half bit periods.
// - Clock select picks 2, 8, 32 or RC.
// - RC source gives a bit period near 4 us.
// - Selected pin is converted, even when driven.
// - Channel and direction never gate a conversion.
// - Analog-configured pins read zero from the port.
// - Digital-input pins still convert when selected.
// - Clearing start aborts; result keeps old value.
// - Result holds last conversion or last write.
// - After abort, wait two bit periods, then acquire.
// - RC source delays start by one instruction cycle.
// - Completion in sleep with irq enabled wakes core.
// - Completion in sleep, irq disabled, powers down.
// - Sleep with non-RC source aborts and powers down.
// - Reset clears controls, turns off, aborts conversion.
// - Non power-on reset keeps the result register.
// - Code steps at one LSb, reference over 256.
// - Completion sets done flag and clears start bit.
// - Channel select codes map to inputs 0 to 3.
// - Pin config selects analog pins and reference.
// - Start works only while converter is on.
package sac_pkg;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] SAC_OFS_PORT    = 8'h05;
    localparam logic [7:0] SAC_OFS_INTCTL  = 8'h0B;
    localparam logic [7:0] SAC_OFS_INTCTL2 = 8'h8B;
    localparam logic [7:0] SAC_OFS_FLAGS   = 8'h0C;
    localparam logic [7:0] SAC_OFS_RESULT  = 8'h1E;
    localparam logic [7:0] SAC_OFS_CTRL    = 8'h1F;
    localparam logic [7:0] SAC_OFS_DIR     = 8'h85;
    localparam logic [7:0] SAC_OFS_ENABLES = 8'h8C;
    localparam logic [7:0] SAC_OFS_PINCFG  = 8'h9F;

    // Field positions.
    localparam int SAC_CTL_CLKSEL_LO = 6;
    localparam int SAC_CTL_CHAN_LO   = 3;
    localparam int SAC_CTL_GO        = 2;
    localparam int SAC_CTL_ON        = 0;
    localparam int SAC_DONE_BIT      = 6;
    localparam int SAC_GIE_BIT       = 7;
    localparam int SAC_PERIPH_IRQ_ENABLE_BIT      = 6;

    // Values after reset.
    localparam logic [7:0] SAC_CTRL_RST   = 8'h00;
    localparam logic [2:0] SAC_PINCFG_RST = 3'h0;
    localparam logic [5:0] SAC_DIR_RST    = 6'h3F;
    localparam logic [7:0] SAC_INTCTL_RST = 8'h00;

    // Clock select codes.
    localparam logic [1:0] SAC_CLK_RC = 2'h3;

    // Timing: the oscillator period is the clk period.
    localparam int SAC_CLK_NS      = 10;
    localparam int SAC_RC_BIT_NS   = 4000;
    localparam int SAC_RC_HALF_CYC = (SAC_RC_BIT_NS / 2) / SAC_CLK_NS;
    localparam int SAC_INSTR_CYC   = 4;
    localparam int SAC_CONV_HALVES = 19;
    localparam int SAC_HOLD_HALVES = 4;
    localparam int SAC_FIRST_BIT_H = 2;

    typedef enum logic [2:0] {
        SAC_ACQ   = 3'h0,
        SAC_DELAY = 3'h1,
        SAC_CONV  = 3'h3,
        SAC_HOLD  = 3'h2,
        SAC_OFF   = 3'h6
    } sac_state_type;

endpackage

//--- hdl/sac_conv_ctrl.sv
// Control logic of the 8-bit successive-approximation converter.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl
    import sac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       sleep,
    input  wire logic [5:0] pin_in,
    output logic      [5:0] pin_out,
    output logic      [5:0] pin_oe,
    input  wire logic       cmp_above,
    output logic      [7:0] dac_code,
    output logic      [1:0] channel_select,
    output logic            vref_from_pin,
    output logic            analog_power,
    output logic            sample_hold,
    output logic            conv_irq,
    output logic            wake_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0]    ctl;
        logic [2:0]    pincfg;
        logic [5:0]    dir;
        logic [5:0]    latch;
        logic [7:0]    intctl;
        logic          done_flag;
        logic          done_irq_en;
        logic [7:0]    result;
        logic [7:0]    sar;
        sac_state_type state;
        logic [8:0]    div;
        logic [4:0]    half;
        logic          sleep_off;
        logic [7:0]    rdata;
        logic          wake;
    } sac_regs_type;

    sac_regs_type st_r;
    sac_regs_type st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Pins read as zero while they are analog; bit order is GP5..GP0.
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        logic [5:0] m;
        m = 6'h00;
        case (cfg)
            3'h0: m = 6'h17;
            3'h1: m = 6'h15;
            3'h2: m = 6'h07;
            3'h3: m = 6'h05;
            3'h4: m = 6'h03;
            3'h5: m = 6'h01;
            3'h6: m = 6'h01;
            default: m = 6'h00;
        endcase
        return m;
    endfunction

    // Half of a bit period in clk cycles, minus one, for a clock select code.
    function automatic logic [8:0] half_reload(input logic [1:0] sel);
        logic [8:0] r;
        r = 9'h000;
        case (sel)
            2'h0: r = 9'h000;
            2'h1: r = 9'h003;
            2'h2: r = 9'h00F;
            default: r = 9'(SAC_RC_HALF_CYC - 1);
        endcase
        return r;
    endfunction

    logic [1:0] clk_sel;
    logic       conv_on;
    logic       go_bit;
    logic       half_tick;
    logic [2:0] bit_idx;
    logic [7:0] trial_mask;
    logic [4:0] bit_step;

    assign clk_sel    = st_r.ctl[SAC_CTL_CLKSEL_LO +: 2];
    assign conv_on    = st_r.ctl[SAC_CTL_ON];
    assign go_bit     = st_r.ctl[SAC_CTL_GO];
    // The divider runs through every timed state; a single-cycle enable, not a clock.
    assign half_tick  = (st_r.div == 9'h000);
    assign bit_step   = 5'(st_r.half - 5'(SAC_FIRST_BIT_H));
    assign bit_idx    = 3'(3'h7 - bit_step[3:1]);
    assign trial_mask = (st_r.state == SAC_CONV && st_r.half >= 5'(SAC_FIRST_BIT_H)
                         && st_r.half < 5'(SAC_CONV_HALVES - 1))
                        ? (8'h01 << bit_idx) : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.wake  = 1'b0;

        // Divider: reload on each half tick, otherwise count down.
        if (half_tick) begin
            st_nxt.div = half_reload(clk_sel);
        end else begin
            st_nxt.div = 9'(st_r.div - 9'h001);
        end

        // Register reads; data appear in the following cycle only.
        if (rd) begin
            if (addr == SAC_OFS_PORT) begin
                st_nxt.rdata = {2'h0, pin_in & ~analog_mask(st_r.pincfg)};
            end else if (addr == SAC_OFS_INTCTL || addr == SAC_OFS_INTCTL2) begin
                st_nxt.rdata = st_r.intctl;
            end else if (addr == SAC_OFS_FLAGS) begin
                st_nxt.rdata = 8'(st_r.done_flag) << SAC_DONE_BIT;
            end else if (addr == SAC_OFS_RESULT) begin
                st_nxt.rdata = st_r.result;
            end else if (addr == SAC_OFS_CTRL) begin
                st_nxt.rdata = st_r.ctl;
            end else if (addr == SAC_OFS_DIR) begin
                st_nxt.rdata = {2'h0, st_r.dir};
            end else if (addr == SAC_OFS_ENABLES) begin
                st_nxt.rdata = 8'(st_r.done_irq_en) << SAC_DONE_BIT;
            end else if (addr == SAC_OFS_PINCFG) begin
                st_nxt.rdata = {5'h00, st_r.pincfg};
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // Register writes.
        if (wr) begin
            if (addr == SAC_OFS_PORT) begin
                st_nxt.latch = wdata[5:0];
            end else if (addr == SAC_OFS_INTCTL || addr == SAC_OFS_INTCTL2) begin
                st_nxt.intctl = wdata;
            end else if (addr == SAC_OFS_FLAGS) begin
                st_nxt.done_flag = wdata[SAC_DONE_BIT];
            end else if (addr == SAC_OFS_RESULT) begin
                st_nxt.result = wdata;
            end else if (addr == SAC_OFS_CTRL) begin
                st_nxt.ctl = wdata;
                // The start bit only takes while the converter was already on.
                st_nxt.ctl[SAC_CTL_GO] = wdata[SAC_CTL_GO] & conv_on;
            end else if (addr == SAC_OFS_DIR) begin
                st_nxt.dir = wdata[5:0];
            end else if (addr == SAC_OFS_ENABLES) begin
                st_nxt.done_irq_en = wdata[SAC_DONE_BIT];
            end else if (addr == SAC_OFS_PINCFG) begin
                st_nxt.pincfg = wdata[2:0];
            end
        end

        // Power-down by sleep lasts until the core leaves sleep.
        if (!sleep) begin
            st_nxt.sleep_off = 1'b0;
        end

        // Sequencer.
        case (st_r.state)
            SAC_OFF: begin
                if (st_nxt.ctl[SAC_CTL_ON]) begin
                    st_nxt.state = SAC_ACQ;
                end
            end
            SAC_ACQ: begin
                // Channel and pin direction do not gate the start.
                if (go_bit) begin
                    st_nxt.sar  = 8'h00;
                    st_nxt.half = 5'h00;
                    if (clk_sel == SAC_CLK_RC) begin
                        st_nxt.div   = 9'(SAC_INSTR_CYC - 1);
                        st_nxt.state = SAC_DELAY;
                    end else begin
                        st_nxt.div   = half_reload(clk_sel);
                        st_nxt.state = SAC_CONV;
                    end
                end
            end
            SAC_DELAY: begin
                if (half_tick) begin
                    st_nxt.state = SAC_CONV;
                end
            end
            SAC_CONV: begin
                if (half_tick) begin
                    st_nxt.half = 5'(st_r.half + 5'h01);
                    // A bit is settled at the end of its whole bit period.
                    if (trial_mask != 8'h00 && st_r.half[0]) begin
                        st_nxt.sar = cmp_above ? (st_r.sar | trial_mask)
                                               : (st_r.sar & ~trial_mask);
                    end
                    if (st_r.half == 5'(SAC_CONV_HALVES - 1)) begin
                        st_nxt.result           = st_r.sar;
                        st_nxt.ctl[SAC_CTL_GO]  = 1'b0;
                        st_nxt.done_flag        = 1'b1;
                        st_nxt.half             = 5'h00;
                        st_nxt.state            = SAC_HOLD;
                        if (sleep && st_r.done_irq_en) begin
                            st_nxt.wake = 1'b1;
                        end else if (sleep) begin
                            st_nxt.sleep_off = 1'b1;
                        end
                    end
                end
            end
            SAC_HOLD: begin
                if (half_tick) begin
                    st_nxt.half = 5'(st_r.half + 5'h01);
                    if (st_r.half == 5'(SAC_HOLD_HALVES - 1)) begin
                        st_nxt.state = SAC_ACQ;
                    end
                end
            end
            default: begin
                st_nxt.state = SAC_OFF;
            end
        endcase

        // Clearing the start bit mid-conversion abandons it; result untouched.
        if ((st_r.state == SAC_CONV || st_r.state == SAC_DELAY)
            && !st_nxt.ctl[SAC_CTL_GO] && st_nxt.state != SAC_HOLD) begin
            st_nxt.result = st_nxt.result;
            // Restart the divider so the hold is two whole bit periods from the abort.
            st_nxt.div    = half_reload(clk_sel);
            st_nxt.half   = 5'h00;
            st_nxt.state  = SAC_HOLD;
        end

        // Sleep on an oscillator clock stops the oscillator: power down even when
        // idle, and abort a running conversion.
        if (sleep && clk_sel != SAC_CLK_RC) begin
            st_nxt.sleep_off = 1'b1;
            if (st_r.state == SAC_CONV || st_r.state == SAC_DELAY) begin
                st_nxt.ctl[SAC_CTL_GO] = 1'b0;
                st_nxt.div             = half_reload(clk_sel);
                st_nxt.half            = 5'h00;
                st_nxt.state           = SAC_HOLD;
            end
        end

        // Hardware setting the done flag wins over a clearing write.
        if (st_r.state == SAC_CONV && st_nxt.state == SAC_HOLD && st_nxt.wake) begin
            st_nxt.done_flag = 1'b1;
        end
        if (st_r.state == SAC_CONV && half_tick
            && st_r.half == 5'(SAC_CONV_HALVES - 1)) begin
            st_nxt.done_flag = 1'b1;
        end

        // Switching off shuts the module down and drops any conversion.
        if (!st_nxt.ctl[SAC_CTL_ON]) begin
            st_nxt.ctl[SAC_CTL_GO] = 1'b0;
            st_nxt.state           = SAC_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers. The result is not touched by reset, so it is unknown only
    // after power-up.

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r             <= '0;
            st_r.ctl         <= SAC_CTRL_RST;
            st_r.pincfg      <= SAC_PINCFG_RST;
            st_r.dir         <= SAC_DIR_RST;
            st_r.intctl      <= SAC_INTCTL_RST;
            st_r.state       <= SAC_OFF;
            st_r.result      <= st_r.result;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rdata          = st_r.rdata;
    assign pin_out        = st_r.latch;
    assign pin_oe         = ~st_r.dir;
    assign dac_code       = st_r.sar | trial_mask;
    assign channel_select = st_r.ctl[SAC_CTL_CHAN_LO +: 2];
    // Reference comes from pin 1 on the odd codes below all-digital.
    assign vref_from_pin  = st_r.pincfg[0] && (st_r.pincfg != 3'h7);
    // Converter-on bit may read set while sleep holds the analog part off.
    assign analog_power   = conv_on && !st_r.sleep_off;
    assign sample_hold    = (st_r.state == SAC_ACQ) && analog_power;
    assign conv_irq       = st_r.done_flag && st_r.done_irq_en
                            && st_r.intctl[SAC_PERIPH_IRQ_ENABLE_BIT] && st_r.intctl[SAC_GIE_BIT];
    assign wake_pulse     = st_r.wake;

endmodule

`default_nettype wire

//--- sim/sac_analog_model.sv
// Behavioural model of the four analog inputs and the comparator.
`timescale 1ns/1ps
`default_nettype none

module sac_analog_model (
    input  wire logic [31:0] chan_level,
    input  wire logic [1:0]  channel_select,
    input  wire logic [7:0]  dac_code,
    input  wire logic        analog_power,
    output logic             cmp_above
);
    logic [7:0] vin;

    // The selected pin is converted whatever its digital setup is.
    assign vin = chan_level[channel_select*8 +: 8];
    // Unpowered, the comparator answers nothing useful, so it follows the trial code.
    assign cmp_above = analog_power ? (vin >= dac_code) : dac_code[0];
endmodule

`default_nettype wire

//--- sim/sac_conv_ctrl_assertions.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl_assertions
    import sac_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       sleep,
    input wire logic [5:0] pin_oe,
    input wire logic [1:0] channel_select,
    input wire logic       vref_from_pin,
    input wire logic       analog_power,
    input wire logic       sample_hold,
    input wire logic       conv_irq,
    input wire logic       wake_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [1:0] clksel_r;
    logic [2:0] ie_r;

    // Mirror of the register bits that qualify sleep power-down and the interrupt.
    always_ff @(posedge clk) begin
        if (rst) begin
            clksel_r <= 2'h0;
            ie_r     <= 3'h0;
        end else if (wr) begin
            case (addr)
                SAC_OFS_CTRL:    clksel_r <= wdata[7:6];
                SAC_OFS_ENABLES: ie_r[0] <= wdata[SAC_DONE_BIT];
                SAC_OFS_INTCTL,
                SAC_OFS_INTCTL2: ie_r[2:1] <= wdata[7:6];
                default:         ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and configuration writes show on the outputs one edge later.
    power_off_a: assert property (
        wr && addr == SAC_OFS_CTRL && !wdata[0] |=> !analog_power)
        else $error("converter still powered after switch-off");
    power_on_a: assert property (
        wr && addr == SAC_OFS_CTRL && wdata[0] && !sleep |=> analog_power)
        else $error("converter not powered after switch-on");
    chan_route_a: assert property (
        wr && addr == SAC_OFS_CTRL |=> channel_select == $past(wdata[4:3]))
        else $error("channel select does not follow control write");
    vref_sel_a: assert property (wr && addr == SAC_OFS_PINCFG |=>
        vref_from_pin == ($past(wdata[0]) && $past(wdata[2:1]) != 2'h3))
        else $error("reference source does not follow pin config");
    reset_off_a: assert property (
        $fell(rst) |-> !analog_power && !conv_irq && pin_oe == 6'h00)
        else $error("state after reset not off");
    sleep_abort_a: assert property (sleep && $past(sleep) && $past(sleep, 2) &&
        clksel_r != SAC_CLK_RC |-> !analog_power)
        else $error("converter powered in sleep without RC clock");
    wake_once_a: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    wake_sleep_a: assert property (wake_pulse |-> sleep)
        else $error("wake pulse outside sleep");
    irq_cause_a: assert property (conv_irq |-> ie_r == 3'h7)
        else $error("interrupt without all enables");

    cover property (wake_pulse);
    cover property (conv_irq);
    cover property ($rose(sample_hold));
endmodule

bind sac_conv_ctrl sac_conv_ctrl_assertions u_sac_conv_ctrl_assertions (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .sleep(sleep),
    .pin_oe(pin_oe), .channel_select(channel_select), .vref_from_pin(vref_from_pin),
    .analog_power(analog_power), .sample_hold(sample_hold), .conv_irq(conv_irq),
    .wake_pulse(wake_pulse));

`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end

module tb
    import sac_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rng = 8'h5D, d, rdata, dac_code;
    logic [5:0]  pin_in = 6'h00, pin_out, pin_oe;
    logic [31:0] lvl = 32'h0;
    logic [1:0]  channel_select;
    logic        cmp_above, vref_from_pin, analog_power, sample_hold, conv_irq, wake_pulse;
    int          mismatches = 0, checked = 0, cyc = 0, t;
    logic [7:0]  ofs [7] = '{SAC_OFS_CTRL, SAC_OFS_PINCFG, SAC_OFS_DIR, SAC_OFS_FLAGS,
                             SAC_OFS_ENABLES, SAC_OFS_INTCTL, 8'h40};
    logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};

    sac_conv_ctrl u_sac_conv_ctrl (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .cmp_above(cmp_above), .dac_code(dac_code),
        .channel_select(channel_select), .vref_from_pin(vref_from_pin),
        .analog_power(analog_power), .sample_hold(sample_hold), .conv_irq(conv_irq),
        .wake_pulse(wake_pulse));
    sac_analog_model u_sac_analog_model (.chan_level(lvl), .channel_select(channel_select),
        .dac_code(dac_code), .analog_power(analog_power), .cmp_above(cmp_above));

    ////////////////////////////////////////////////////////////////////////
    // Shift register for repeatable stimulus.
    function automatic logic [7:0] step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Half bit period in clock cycles for each clock select code.
    function automatic int half_of(input logic [1:0] cs);
        return (cs == SAC_CLK_RC) ? SAC_RC_HALF_CYC : (1 << (2 * cs));
    endfunction
    // Channel pins per pin configuration code; a pin carrying the reference is no channel.
    function automatic logic [5:0] amask(input logic [2:0] cfg);
        case (cfg)
            3'h0:       return 6'h17;
            3'h1:       return 6'h15;
            3'h2:       return 6'h07;
            3'h3:       return 6'h05;
            3'h4:       return 6'h03;
            3'h5, 3'h6: return 6'h01;
            default:    return 6'h00;
        endcase
    endfunction

    task automatic end_of_test();
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        `CHK("register", e, d)
    endtask
    // Polls the busy bit; the bound keeps a stuck conversion from hanging here.
    task automatic wait_go();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            addr <= SAC_OFS_CTRL;
            rd   <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 n++;
        end while (rdata[SAC_CTL_GO] !== 1'b0 && n < 6000);
    endtask
    task automatic conv(input logic [1:0] cs, input logic [1:0] ch, input logic [7:0] v);
        lvl[ch*8 +: 8] <= v;
        // Oscillator codes are far below the 1.6 us floor at this clock; the ideal
        // comparator settles at once, so only the sequencing is exercised by them.
        wreg(SAC_OFS_CTRL, {cs, 1'b0, ch, 3'h1});
        repeat (8) @(posedge clk);
        t = cyc;
        wreg(SAC_OFS_CTRL, {cs, 1'b0, ch, 3'h5});
        wait_go();
        t = cyc - t - 19 * half_of(cs);
        `CHK("conv_cycles", 1'b1, t >= 0 && t < 20)
        rreg(SAC_OFS_RESULT, v);
        rreg(SAC_OFS_FLAGS, 8'h40);
        wreg(SAC_OFS_FLAGS, 8'h00);
        repeat (4 * half_of(cs) + 8) @(posedge clk);
    endtask

    always #5 clk = ~clk;
    // Cycle count; running past the ceiling ends the run as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: registers, port reads, conversions, abort, sleep, reset.
    initial begin
        repeat (6) @(posedge clk);
        rst    <= 1'b0;
        pin_in <= rng[5:0];
        foreach (ofs[i]) rreg(ofs[i], rstv[i]);
        wreg(SAC_OFS_DIR, 8'h2A);
        #1 `CHK("pin_oe", 6'h15, pin_oe)
        wreg(SAC_OFS_PORT, 8'h2D);
        #1 `CHK("pin_out", 6'h2D, pin_out)
        wreg(SAC_OFS_DIR, 8'h3F);
        for (int c = 0; c < 8; c++) begin
            wreg(SAC_OFS_PINCFG, 8'(c));
            rreg(SAC_OFS_PORT, {2'h0, pin_in & ~amask(3'(c))});
        end
        for (int c = 0; c < 10; c++) begin
            rng = step(rng);
            conv(c < 4 ? 2'(c) : 2'h0, rng[1:0], c == 0 ? 8'h00 : c == 1 ? 8'hFF : rng);
        end
        wreg(SAC_OFS_RESULT, 8'h3C);
        rreg(SAC_OFS_RESULT, 8'h3C);
        wreg(SAC_OFS_CTRL, 8'h81);
        repeat (8) @(posedge clk);
        wreg(SAC_OFS_CTRL, 8'h85);
        repeat (60) @(posedge clk);
        wreg(SAC_OFS_CTRL, 8'h81);
        t = cyc;
        #1 `CHK("abort_hold", 1'b0, sample_hold)
        while (sample_hold !== 1'b1 && cyc - t < 200) #10;
        // Two bit periods of the /32 clock are four halves, plus the strobe edge.
        t = cyc - t - 4 * half_of(2'h2);
        `CHK("abort_wait", 1'b1, t >= 0 && t < 4)
        rreg(SAC_OFS_RESULT, 8'h3C);
        rreg(SAC_OFS_FLAGS, 8'h00);
        wreg(SAC_OFS_CTRL, 8'h00);
        wreg(SAC_OFS_CTRL, 8'h05);
        repeat (40) @(posedge clk);
        rreg(SAC_OFS_CTRL, 8'h01);
        wreg(SAC_OFS_CTRL, 8'h45);
        repeat (10) @(posedge clk);
        sleep <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK("sleep_power", 1'b0, analog_power)
        rreg(SAC_OFS_CTRL, 8'h41);
        rreg(SAC_OFS_RESULT, 8'h3C);
        @(posedge clk) sleep <= 1'b0;
        lvl[7:0] <= 8'h96;
        wreg(SAC_OFS_ENABLES, 8'h40);
        wreg(SAC_OFS_INTCTL, 8'hC0);
        rreg(SAC_OFS_INTCTL2, 8'hC0);
        wreg(SAC_OFS_CTRL, 8'hC1);
        repeat (8) @(posedge clk);
        wreg(SAC_OFS_CTRL, 8'hC5);
        sleep <= 1'b1;
        t = cyc;
        // Look just after each edge, where the one-cycle wake pulse has settled.
        #1;
        while (wake_pulse !== 1'b1 && cyc - t < 9000) #10;
        `CHK("wake", 1'b1, wake_pulse)
        `CHK("irq", 1'b1, conv_irq)
        @(posedge clk) sleep <= 1'b0;
        rreg(SAC_OFS_RESULT, 8'h96);
        rreg(SAC_OFS_CTRL, 8'hC1);
        wreg(SAC_OFS_FLAGS, 8'h00);
        wreg(SAC_OFS_ENABLES, 8'h00);
        repeat (820) @(posedge clk);
        wreg(SAC_OFS_CTRL, 8'hC5);
        sleep <= 1'b1;
        wait_go();
        repeat (900) @(posedge clk);
        #1 `CHK("sleep_done_power", 1'b0, analog_power)
        rreg(SAC_OFS_CTRL, 8'hC1);
        @(posedge clk) sleep <= 1'b0;
        wreg(SAC_OFS_RESULT, 8'hA5);
        wreg(SAC_OFS_CTRL, 8'h81);
        repeat (4) @(posedge clk);
        wreg(SAC_OFS_CTRL, 8'h85);
        repeat (20) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(SAC_OFS_CTRL, 8'h00);
        rreg(SAC_OFS_RESULT, 8'hA5);
        `CHK("reset_power", 1'b0, analog_power)
        end_of_test();
    end
endmodule

`default_nettype wire
